// ---- rtl/tcq_defines.svh ----
// Offsets, field positions, reset values and timing counts of the block.
`ifndef TCQ_DEFINES_SVH
`define TCQ_DEFINES_SVH
`define TCQ_CLK_PERIOD_NS 8
`define TCQ_US_NS 1000
`define TCQ_TICK_CYCLES (`TCQ_US_NS / `TCQ_CLK_PERIOD_NS)
`define TCQ_HOLDOFF_MAX_US 10000000
`define TCQ_REG_CTRL 12'h000
`define TCQ_REG_LINE_SEL 12'h004
`define TCQ_REG_FILTER 12'h008
`define TCQ_REG_HOLDOFF 12'h00c
`define TCQ_REG_STAT_SEL 12'h010
`define TCQ_REG_STATUS 12'h014
`define TCQ_REG_SW_TRIG 12'h018
`define TCQ_REG_FRAMES 12'h01c
`define TCQ_REG_TSTAMP 12'h020
`define TCQ_REG_QLEVEL 12'h024
`define TCQ_CTRL_EXP_EN 0
`define TCQ_CTRL_OVR_EN 1
`define TCQ_CTRL_FREE_RUN 2
`define TCQ_CTRL_RESET 3'h0
`define TCQ_FILTER_RESET 20'h00000
`define TCQ_HOLDOFF_RESET 24'h000000
`define TCQ_SEL_AWAIT 2'h1
`define TCQ_SEL_RESET 2'h0
`define TCQ_EVT_EXPOSURE 8'h01
`define TCQ_EVT_OVERRUN 8'h02
`define TCQ_STREAM_CHANNEL 8'h00
`endif

// ---- rtl/tcq_pkg.sv ----
// Types shared by the trigger conditioning and event queue files.
package tcq_pkg;
  typedef enum logic {MSG_IDLE, MSG_SEND} msg_state_t;
  typedef logic [63:0] evt_record_t;
endpackage

// ---- rtl/input_filter.sv ----
// Debounce filter for one input line with a microsecond hold time.
`timescale 1ns/1ns
module input_filter #(
  parameter int W = 20
) (
  input wire logic clk_in, // Device clock.
  input wire logic srst_in, // Synchronous reset, active high.
  input wire logic ce_in, // Clock enable.
  input wire logic tick_in, // One-microsecond tick.
  input wire logic pin_in, // Raw asynchronous line.
  input wire logic [W-1:0] time_us_in, // Filter time in microseconds.
  output logic level_out, // Accepted line level.
  output logic rise_out // One-cycle pulse on accepted rise.
);
  logic sync1_q, sync2_q, prev_q; // Synchroniser and last sample.
  logic [W-1:0] cnt_q; // Microseconds the new level has held.

  // Two flops bring the pin into the clock domain.
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      prev_q <= 1'b0;
    end else if (ce_in) begin
      sync1_q <= pin_in;
      sync2_q <= sync1_q;
      prev_q <= sync2_q;
    end
  end

  // A level is taken only after it has held for the whole time.
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      cnt_q <= '0;
      level_out <= 1'b0;
      rise_out <= 1'b0;
    end else if (ce_in) begin
      rise_out <= 1'b0;
      if (sync2_q != prev_q) begin
        cnt_q <= '0;
      end else if (sync2_q != level_out) begin
        if (cnt_q >= time_us_in) begin
          level_out <= sync2_q;
          rise_out <= sync2_q;
          cnt_q <= '0;
        end else if (tick_in) begin
          cnt_q <= cnt_q + 1'b1;
        end
      end else begin
        cnt_q <= '0;
      end
    end
  end
endmodule // input_filter

// ---- rtl/event_queue.sv ----
// Circular queue holding event records until they are sent.
`timescale 1ns/1ns
module event_queue #(
  parameter int WIDTH = 64,
  parameter int DEPTH = 8,
  parameter int AW = 3
) (
  input wire logic clk_in, // Device clock.
  input wire logic srst_in, // Synchronous reset, active high.
  input wire logic ce_in, // Clock enable.
  input wire logic push_in, // Store a record; ignored when full.
  input wire logic [WIDTH-1:0] push_data_in, // Record to store.
  input wire logic pop_in, // Remove the head record.
  output logic [WIDTH-1:0] head_out, // Oldest record.
  output logic [AW:0] count_out, // Records held.
  output logic full_out, // No free slot.
  output logic empty_out // No record held.
);
  logic [WIDTH-1:0] mem_q [DEPTH]; // Record storage.
  logic [AW-1:0] wr_q, rd_q; // Write and read pointers.

  assign full_out = (count_out == (AW+1)'(DEPTH));
  assign empty_out = (count_out == '0);
  assign head_out = mem_q[rd_q];

  // Pointers and level move on accepted pushes and pops.
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      wr_q <= '0;
      rd_q <= '0;
      count_out <= '0;
    end else if (ce_in) begin
      if (push_in && !full_out) begin
        wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
      end
      if (pop_in && !empty_out) begin
        rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
      end
      count_out <= count_out + (AW+1)'(push_in && !full_out)
                 - (AW+1)'(pop_in && !empty_out);
    end
  end

  // Storage needs no reset; only written slots are ever read.
  always_ff @(posedge clk_in) begin
    if (ce_in && push_in && !full_out) begin
      mem_q[wr_q] <= push_data_in;
    end
  end
endmodule // event_queue

// ---- rtl/trigger_conditioning_event_queue.sv ----
// Trigger conditioning, capture status and event messages on AHB-Lite.
// Overview of operation
// - Accept level only after filter time held.
// - Pulses shorter than filter time are dropped.
// - Accepted edges emerge delayed by filter time.
// - Filter time in microseconds, zero to ~1s.
// - Separate filter time per line, via select.
// - Hardware trigger waits programmable hold-off.
// - Zero hold-off fires hardware trigger immediately.
// - No hold-off for software or free-run.
// - Ready flag shows software trigger acceptance.
// - No readable status for acquisition start.
// - Only exposure-end and overrun events exist.
// - Record: type, channel zero, frame, timestamp.
// - Timestamp field is 32 bits wide.
// - Events queued, sent when bus allows.
// - One message carries all events queued at its start.
// - Events dropped while queue is full.
// - Overrun event queued when overrun enabled.
// - Overrun event carries no drop details.
// - Events only when enabled; host receives.
//
// Decided for this implementation: the address map and the AHB-Lite slave port.
`timescale 1ns/1ns
`include "tcq_defines.svh"
module trigger_conditioning_event_queue #(
  parameter int FW = 20, // Filter time width, about one second.
  parameter int HW = 24, // Hold-off width.
  parameter int HOLDOFF_MAX_US = `TCQ_HOLDOFF_MAX_US, // Hold-off limit.
  parameter int QDEPTH = 8, // Event queue depth.
  parameter int QAW = 3 // Queue pointer width.
) (
  input wire logic clk_in, // Device clock, 125 MHz.
  input wire logic srst_in, // Synchronous reset, active high.
  input wire logic ce_in, // Clock enable; low freezes all state.
  input wire logic hsel_in, // AHB slave select.
  input wire logic [31:0] haddr_in, // AHB address.
  input wire logic [1:0] htrans_in, // AHB transfer type.
  input wire logic hwrite_in, // AHB write.
  input wire logic [2:0] hsize_in, // AHB size, word only.
  input wire logic [31:0] hwdata_in, // AHB write data.
  input wire logic hready_in, // AHB bus ready.
  output logic [31:0] hrdata_out, // AHB read data.
  output logic hreadyout_out, // AHB slave ready.
  output logic hresp_out, // AHB response, always OKAY.
  input wire logic [1:0] line_in, // Raw input lines.
  input wire logic camera_idle_in, // Core can start a frame.
  input wire logic exposure_end_in, // Pulse at end of exposure.
  output logic frame_trigger_out, // Pulse that starts a frame.
  output logic [1:0] line_level_out, // Filtered line levels.
  output logic evt_valid_out, // Event word offered.
  input wire logic evt_ready_in, // Transmit slot available.
  output tcq_pkg::evt_record_t evt_data_out, // Event record.
  output logic evt_first_out, // First record of a message.
  output logic evt_last_out // Last record of a message.
);
  import tcq_pkg::*;

  // Builds one event record; used for both event kinds.
  function automatic evt_record_t make_record(input logic [7:0] kind,
                                              input logic [15:0] frame,
                                              input logic [31:0] ts);
    make_record = {kind, `TCQ_STREAM_CHANNEL, frame, ts};
  endfunction

  logic [6:0] tick_cnt_q; // Divider for the microsecond tick.
  logic tick; // One-cycle microsecond pulse.
  logic [31:0] tstamp_q; // Free microsecond timestamp.
  logic [31:0] frames_q; // Frames started since reset.
  logic act_q; // A data phase is pending.
  logic wr_q; // Pending data phase is a write.
  logic [11:0] addr_q; // Address of the pending data phase.
  logic [31:0] rd_data; // Read mux for the address phase.
  logic we; // Register write strobe.
  logic [2:0] ctrl_q; // Event enables and free-run mode.
  logic line_sel_q; // input_line_select.
  logic [FW-1:0] filter_time_q [2]; // input_filter_time_us per line.
  logic [HW-1:0] holdoff_q; // trigger_holdoff_us.
  logic [1:0] status_sel_q; // capture_status_select.
  logic sw_trig_q; // Software trigger request pulse.
  logic [1:0] line_rise; // Accepted rising edges.
  logic free_run; // Continuous frame mode.
  logic hold_busy_q; // A hardware trigger is being held off.
  logic [HW-1:0] hold_cnt_q; // Microseconds held so far.
  logic hw_trig, hw_fire, sw_fire, fr_fire; // Trigger sources.
  logic awaiting_frame_trigger; // Software trigger would be taken.
  logic capture_ready_flag; // Selected status bit.
  logic exp_ev, push_ovr, push_exp, drop; // Queue write decisions.
  logic ovr_pend_q; // Overrun event still to be queued.
  logic q_push, q_pop, q_full, q_empty; // Queue handshake.
  evt_record_t q_data; // Record being pushed.
  logic [QAW:0] q_count; // Records held.
  msg_state_t msg_state_q; // Message builder state.
  logic [QAW:0] batch_left_q; // Records still to send in message.

  assign free_run = ctrl_q[`TCQ_CTRL_FREE_RUN];

  // The microsecond tick paces every filter and hold-off counter.
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      tick_cnt_q <= '0;
    end else if (ce_in) begin
      if (tick) begin
        tick_cnt_q <= '0;
      end else begin
        tick_cnt_q <= tick_cnt_q + 1'b1;
      end
    end
  end
  assign tick = (tick_cnt_q == 7'(`TCQ_TICK_CYCLES - 1));

  // The timestamp wraps after about 71 minutes.
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      tstamp_q <= '0;
    end else if (ce_in && tick) begin
      tstamp_q <= tstamp_q + 1'b1;
    end
  end

  // One filter per line, each with its own time.
  for (genvar i = 0; i < 2; i++) begin : g_line
    input_filter #(.W(FW)) u_filter (
      .clk_in(clk_in),
      .srst_in(srst_in),
      .ce_in(ce_in),
      .tick_in(tick),
      .pin_in(line_in[i]),
      .time_us_in(filter_time_q[i]),
      .level_out(line_level_out[i]),
      .rise_out(line_rise[i])
    );
  end

  // Zero-wait slave: every transfer completes OKAY at once.
  assign hreadyout_out = 1'b1;
  assign hresp_out = 1'b0;
  assign we = act_q && wr_q;

  // Address phase capture; read data is latched here so it is a flop.
  // The master idles between transfers, so no write is bypassed.
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      act_q <= 1'b0;
      wr_q <= 1'b0;
      addr_q <= '0;
      hrdata_out <= '0;
    end else if (ce_in) begin
      if (hsel_in && htrans_in[1] && hready_in) begin
        act_q <= 1'b1;
        wr_q <= hwrite_in;
        addr_q <= haddr_in[11:0];
        hrdata_out <= hwrite_in ? '0 : rd_data;
      end else begin
        act_q <= 1'b0;
      end
    end
  end

  // Read mux; unmapped words read as zero.
  always_comb begin
    rd_data = '0;
    unique case (haddr_in[11:0])
      `TCQ_REG_CTRL: rd_data = {29'h0, ctrl_q};
      `TCQ_REG_LINE_SEL: rd_data = {31'h0, line_sel_q};
      `TCQ_REG_FILTER: rd_data = 32'(filter_time_q[line_sel_q]);
      `TCQ_REG_HOLDOFF: rd_data = 32'(holdoff_q);
      `TCQ_REG_STAT_SEL: rd_data = {30'h0, status_sel_q};
      `TCQ_REG_STATUS: rd_data = {14'h0, ovr_pend_q, hold_busy_q,
                                  6'h0, line_level_out,
                                  7'h0, capture_ready_flag};
      `TCQ_REG_FRAMES: rd_data = frames_q;
      `TCQ_REG_TSTAMP: rd_data = tstamp_q;
      `TCQ_REG_QLEVEL: rd_data = 32'(q_count);
      default: rd_data = '0;
    endcase
  end

  // Software-written settings.
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      ctrl_q <= `TCQ_CTRL_RESET;
      line_sel_q <= 1'b0;
      filter_time_q[0] <= `TCQ_FILTER_RESET;
      filter_time_q[1] <= `TCQ_FILTER_RESET;
      holdoff_q <= `TCQ_HOLDOFF_RESET;
      status_sel_q <= `TCQ_SEL_RESET;
    end else if (ce_in && we) begin
      unique case (addr_q)
        `TCQ_REG_CTRL: ctrl_q <= hwdata_in[2:0];
        `TCQ_REG_LINE_SEL: line_sel_q <= hwdata_in[0];
        `TCQ_REG_FILTER: begin
          filter_time_q[line_sel_q] <= hwdata_in[FW-1:0];
        end
        `TCQ_REG_HOLDOFF: begin
          // Values past the limit are clamped rather than wrapped.
          if (hwdata_in > 32'(HOLDOFF_MAX_US)) begin
            holdoff_q <= HW'(HOLDOFF_MAX_US);
          end else begin
            holdoff_q <= hwdata_in[HW-1:0];
          end
        end
        `TCQ_REG_STAT_SEL: status_sel_q <= hwdata_in[1:0];
        default: begin
        end
      endcase
    end
  end

  // A write of one to the trigger word issues a single request.
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      sw_trig_q <= 1'b0;
    end else if (ce_in) begin
      sw_trig_q <= we && (addr_q == `TCQ_REG_SW_TRIG) && hwdata_in[0];
    end
  end

  // Hardware triggers come from line one; free-run ignores them.
  assign hw_trig = line_rise[0] && !free_run;

  // Hold-off timer; a new edge while holding is ignored.
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      hold_busy_q <= 1'b0;
      hold_cnt_q <= '0;
    end else if (ce_in) begin
      if (hold_busy_q) begin
        if (hw_fire) begin
          hold_busy_q <= 1'b0;
        end else if (tick) begin
          hold_cnt_q <= hold_cnt_q + 1'b1;
        end
      end else if (hw_trig && holdoff_q != '0) begin
        hold_busy_q <= 1'b1;
        hold_cnt_q <= '0;
      end
    end
  end

  // Hold-off expiry, or an immediate pass when it is zero.
  // Comparing with >= also ends a hold if the value is lowered.
  assign hw_fire = (!hold_busy_q && hw_trig && holdoff_q == '0) ||
                   (hold_busy_q && tick &&
                    (HW+1)'(hold_cnt_q) + 1'b1 >= (HW+1)'(holdoff_q));

  // Software triggers are taken at once when the core is ready, outside free-run and hold-off.
  assign awaiting_frame_trigger = camera_idle_in && !free_run &&
                                  !hold_busy_q;
  assign sw_fire = sw_trig_q && awaiting_frame_trigger;
  assign fr_fire = free_run && camera_idle_in && !frame_trigger_out;

  // Only the frame-trigger-wait selection reports anything.
  // Acquisition start has no selector value that reads back.
  assign capture_ready_flag = (status_sel_q == `TCQ_SEL_AWAIT) &&
                              awaiting_frame_trigger;

  // Registered frame trigger and frame counter.
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      frame_trigger_out <= 1'b0;
      frames_q <= '0;
    end else if (ce_in) begin
      frame_trigger_out <= hw_fire || sw_fire || fr_fire;
      if (frame_trigger_out) begin
        frames_q <= frames_q + 1'b1;
      end
    end
  end

  // Exposure events need their enable at the moment they happen.
  assign exp_ev = exposure_end_in && ctrl_q[`TCQ_CTRL_EXP_EN];
  // A pending overrun takes the first free slot.
  assign push_ovr = ovr_pend_q && !q_full;
  assign push_exp = exp_ev && !q_full && !push_ovr;
  assign drop = exp_ev && !push_exp;
  assign q_push = push_ovr || push_exp;
  assign q_data = push_ovr ?
    make_record(`TCQ_EVT_OVERRUN, frames_q[15:0], tstamp_q) :
    make_record(`TCQ_EVT_EXPOSURE, frames_q[15:0], tstamp_q);

  // Overrun flag; a new drop wins over the clearing push.
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      ovr_pend_q <= 1'b0;
    end else if (ce_in) begin
      if (drop && ctrl_q[`TCQ_CTRL_OVR_EN]) begin
        ovr_pend_q <= 1'b1;
      end else if (push_ovr) begin
        ovr_pend_q <= 1'b0;
      end
    end
  end

  event_queue #(.WIDTH(64), .DEPTH(QDEPTH), .AW(QAW)) u_queue (
    .clk_in(clk_in),
    .srst_in(srst_in),
    .ce_in(ce_in),
    .push_in(q_push),
    .push_data_in(q_data),
    .pop_in(q_pop),
    .head_out(evt_data_out),
    .count_out(q_count),
    .full_out(q_full),
    .empty_out(q_empty)
  );

  // A message holds the records queued when it starts.
  // Later arrivals wait for the next message.
  assign evt_valid_out = (msg_state_q == MSG_SEND);
  assign evt_last_out = evt_valid_out && (batch_left_q == (QAW+1)'(1));
  assign q_pop = evt_valid_out && evt_ready_in && ce_in;

  // Message builder.
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      msg_state_q <= MSG_IDLE;
      batch_left_q <= '0;
      evt_first_out <= 1'b0;
    end else if (ce_in) begin
      unique case (msg_state_q)
        MSG_IDLE: begin
          if (!q_empty) begin
            batch_left_q <= q_count;
            evt_first_out <= 1'b1;
            msg_state_q <= MSG_SEND;
          end
        end
        MSG_SEND: begin
          if (evt_ready_in) begin
            evt_first_out <= 1'b0;
            batch_left_q <= batch_left_q - 1'b1;
            if (evt_last_out) begin
              msg_state_q <= MSG_IDLE;
            end
          end
        end
      endcase
    end
  end
endmodule // trigger_conditioning_event_queue

// ---- tb/tcq_monitor.sv ----
// Port checker of the trigger and event queue block.
`timescale 1ns/1ns
`include "tcq_defines.svh"
module tcq_monitor (
  input wire logic clk_in, // Device clock.
  input wire logic srst_in, // Synchronous reset, active high.
  input wire logic ce_in, // Clock enable.
  input wire logic hsel_in, // AHB select.
  input wire logic [1:0] htrans_in, // AHB transfer type.
  input wire logic hready_in, // AHB bus ready.
  input wire logic [31:0] hrdata_out, // AHB read data.
  input wire logic [1:0] line_in, // Raw lines.
  input wire logic [1:0] line_level_out, // Filtered levels.
  input wire logic frame_trigger_out, // Frame start pulse.
  input wire logic evt_valid_out, // Event record offered.
  input wire logic evt_ready_in, // Host takes the record.
  input wire tcq_pkg::evt_record_t evt_data_out, // Event record.
  input wire logic evt_first_out, // First record of a message.
  input wire logic evt_last_out // Last record of a message.
);
  // All checks run on the device clock and sleep in reset.
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (srst_in);

  // A beat that closes a message.
  sequence s_last_beat;
    evt_valid_out && evt_ready_in && evt_last_out;
  endsequence
  // A record offered while the host is not taking it.
  sequence s_stalled;
    evt_valid_out && !evt_ready_in;
  endsequence

  a_chan_zero: assert property (evt_valid_out |->
    evt_data_out[55:48] == `TCQ_STREAM_CHANNEL)
    else $error("channel not zero");
  a_type_legal: assert property (evt_valid_out |->
    evt_data_out[63:56] inside {`TCQ_EVT_EXPOSURE, `TCQ_EVT_OVERRUN})
    else $error("unknown event type");
  a_record_held: assert property (s_stalled |=> evt_valid_out &&
    $stable(evt_data_out)) else $error("record changed while stalled");
  a_first_opens: assert property ($rose(evt_valid_out) |->
    evt_first_out) else $error("message opened without first mark");
  a_gap_after_msg: assert property (s_last_beat |=>
    !evt_valid_out) else $error("no idle cycle after message");
  // A slip in the filter would let a level through before it settled.
  a_line_held: assert property ($changed(line_level_out[0]) |->
    $past(line_in[0], 3) == line_level_out[0] &&
    $past(line_in[0], 5) == line_level_out[0])
    else $error("level accepted before it was held");
  a_line_delayed: assert property ($rose(line_in[0]) &&
    !line_level_out[0] |=> !line_level_out[0] [*3])
    else $error("edge passed without delay");
  a_trig_single: assert property (frame_trigger_out |=>
    !frame_trigger_out) else $error("frame trigger longer than a cycle");
  a_rdata_stands: assert property (!(hsel_in && htrans_in[1] &&
    hready_in && ce_in) |=> $stable(hrdata_out))
    else $error("read data moved without a request");
  c_overrun_sent: cover property (evt_valid_out &&
    evt_data_out[63:56] == `TCQ_EVT_OVERRUN);
endmodule // tcq_monitor

bind trigger_conditioning_event_queue tcq_monitor u_mon (.*);

// ---- tb/event_host_model.sv ----
// Host receiver model that takes event records off the message link.
`timescale 1ns/1ns
module event_host_model (
  input wire logic clk_in, // Device clock.
  input wire logic srst_in, // Synchronous reset, active high.
  input wire logic evt_valid_in, // Record offered by the device.
  input wire logic stall_in, // Bench asks the host to stop taking.
  input wire logic slow_in, // Bench asks for one take in four cycles.
  output logic evt_ready_out // Host takes the record.
);
  logic [1:0] pace_q; // Free counter that paces the slow mode.

  // Free-running so slow takes land irregularly.
  always_ff @(posedge clk_in) begin
    pace_q <= srst_in ? 2'h0 : pace_q + 2'h1;
  end

  // Answers only offered records.
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      evt_ready_out <= 1'b0;
    end else begin
      evt_ready_out <= !stall_in && evt_valid_in &&
        (!slow_in || pace_q == 2'h3);
    end
  end
endmodule // event_host_model

// ---- tb/trigger_conditioning_event_queue_tb.sv ----
// Self-checking bench for the trigger and event queue block.
`timescale 1ns/1ns
`include "tcq_defines.svh"
module trigger_conditioning_event_queue_tb;
  import tcq_pkg::*;
  typedef struct packed {logic [31:0] a, v, m;} rexp_t;
  logic clk_in = 1'b0; // Device clock.
  logic srst_in = 1'b1; // Reset, held at the start.
  logic hsel_in = 1'b0; // Bus select.
  logic [31:0] haddr_in = 32'h0; // Bus address.
  logic [1:0] htrans_in = 2'h0; // Bus transfer type.
  logic hwrite_in = 1'b0; // Bus direction.
  logic [31:0] hwdata_in = 32'h0; // Bus write data.
  logic [1:0] line_in = 2'h0; // Raw input lines.
  logic camera_idle_in = 1'b0; // Core ready for a frame.
  logic exposure_end_in = 1'b0; // Exposure end pulse.
  logic stall = 1'b0; // Host stops taking records.
  logic slow = 1'b0; // Host takes records slowly.
  logic rd_pend = 1'b0; // A read data phase is under way.
  logic [31:0] seed = 32'hd67c; // Random state.
  logic [31:0] hrdata_out;
  logic hreadyout_out;
  logic [1:0] line_level_out;
  logic evt_valid_out;
  logic evt_ready_in;
  evt_record_t evt_data_out;
  rexp_t rq[$]; // Expected read results, oldest first.
  logic [7:0] evq[$]; // Expected event types, oldest first.
  int fails = 0;
  int tests_run = 0;

  trigger_conditioning_event_queue dut (.clk_in, .srst_in, .ce_in(1'b1),
    .hsel_in, .haddr_in, .htrans_in, .hwrite_in, .hsize_in(3'h2), .hwdata_in,
    .hready_in(hreadyout_out), .hrdata_out, .hreadyout_out, .hresp_out(),
    .line_in, .camera_idle_in, .exposure_end_in, .frame_trigger_out(),
    .line_level_out, .evt_valid_out, .evt_ready_in, .evt_data_out,
    .evt_first_out(), .evt_last_out());
  event_host_model host (.clk_in, .srst_in, .evt_valid_in(evt_valid_out),
    .stall_in(stall), .slow_in(slow), .evt_ready_out(evt_ready_in));

  // The clock toggles every half period of 8 ns.
  initial begin
    forever #4 clk_in = !clk_in;
  end

  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction

  task automatic print_verdict;
    if (fails == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic chk_reg(input logic [31:0] a, e, g);
    tests_run++;
    if (g !== e) begin
      fails++;
      $display("Error reg %h expected %h seen %h", a, e, g);
    end
  endtask
  task automatic chk_evt(input string n, input logic [7:0] e, g);
    tests_run++;
    if (g !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk_pin(input string n, input logic e, g);
    tests_run++;
    if (g !== e) begin
      fails++;
      $display("Error %s expected %b seen %b", n, e, g);
    end
  endtask

  // One transfer; the master waits on hready, not on a count.
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_in);
    hsel_in <= 1'b1;
    htrans_in <= 2'h2;
    haddr_in <= {20'h0, a};
    hwrite_in <= w;
    do @(posedge clk_in); while (hreadyout_out !== 1'b1);
    hsel_in <= 1'b0;
    htrans_in <= 2'h0;
    hwdata_in <= d;
    rd_pend <= !w;
    do @(posedge clk_in); while (hreadyout_out !== 1'b1);
    rd_pend <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] v, m = '1);
    rq.push_back('{{20'h0, a}, v, m});
    bus(1'b0, a, 32'h0);
  endtask
  task automatic us(input int n);
    repeat (n * `TCQ_TICK_CYCLES) @(posedge clk_in);
  endtask
  // Waiting is bounded so a stuck filter shows as a mismatch.
  task automatic wait_lvl(input int i, input logic v);
    for (int n = 0; n < 2000 && line_level_out[i] !== v; n++)
      @(posedge clk_in);
    chk_pin("line level", v, line_level_out[i]);
  endtask
  // Exposure pulses with random gaps.
  task automatic pulse_exp;
    @(posedge clk_in);
    exposure_end_in <= 1'b1;
    @(posedge clk_in);
    exposure_end_in <= 1'b0;
    seed = xs(seed);
    repeat (seed[1:0]) @(posedge clk_in);
  endtask
  task automatic drain;
    for (int n = 0; n < 3000 && evq.size() > 0; n++)
      @(posedge clk_in);
    chk_pin("queue drained", 1'b1, evq.size() == 0);
  endtask

  // Checks each result against the oldest note.
  always @(posedge clk_in) begin : watch
    rexp_t r;
    if (!srst_in && evt_valid_out === 1'b1 && evt_ready_in === 1'b1) begin
      if (evq.size() == 0) begin
        fails++;
        $display("Error event expected none seen %h", evt_data_out[63:56]);
      end else begin
        chk_evt("event type", evq.pop_front(), evt_data_out[63:56]);
        chk_evt("channel", `TCQ_STREAM_CHANNEL, evt_data_out[55:48]);
      end
    end
    if (rd_pend === 1'b1) begin
      r = rq.pop_front();
      chk_reg(r.a, r.v, hrdata_out & r.m);
    end
  end

  // A hang counts as a mismatch.
  initial begin
    repeat (40000) @(posedge clk_in);
    fails++;
    print_verdict;
  end

  initial begin
    repeat (12) @(posedge clk_in);
    srst_in <= 1'b0;
    rd(`TCQ_REG_CTRL, 32'h0);
    rd(`TCQ_REG_FILTER, 32'h0);
    rd(`TCQ_REG_HOLDOFF, 32'h0);
    wr(`TCQ_REG_HOLDOFF, 32'hffffff);
    rd(`TCQ_REG_HOLDOFF, `TCQ_HOLDOFF_MAX_US);
    wr(`TCQ_REG_HOLDOFF, 32'h0);
    wr(12'h100, 32'h5);
    rd(12'h100, 32'h0);
    // Each line keeps its own filter time.
    wr(`TCQ_REG_FILTER, 32'h3);
    wr(`TCQ_REG_LINE_SEL, 32'h1);
    wr(`TCQ_REG_FILTER, 32'hffffffff);
    rd(`TCQ_REG_FILTER, 32'hfffff);
    wr(`TCQ_REG_FILTER, 32'h5);
    wr(`TCQ_REG_LINE_SEL, 32'h0);
    rd(`TCQ_REG_FILTER, 32'h3);
    line_in[0] <= 1'b1;
    us(1);
    line_in[0] <= 1'b0;
    us(5);
    chk_pin("short pulse", 1'b0, line_level_out[0]);
    line_in[0] <= 1'b1;
    repeat (188) @(posedge clk_in);
    chk_pin("early level", 1'b0, line_level_out[0]);
    wait_lvl(0, 1'b1);
    repeat (4) @(posedge clk_in);
    rd(`TCQ_REG_FRAMES, 32'h1);
    line_in[0] <= 1'b0;
    wait_lvl(0, 1'b0);
    // Too short for the filter time of line two.
    line_in[1] <= 1'b1;
    us(4);
    line_in[1] <= 1'b0;
    us(6);
    chk_pin("line two pulse", 1'b0, line_level_out[1]);
    wr(`TCQ_REG_HOLDOFF, 32'h5);
    line_in[0] <= 1'b1;
    wait_lvl(0, 1'b1);
    us(3);
    rd(`TCQ_REG_FRAMES, 32'h1);
    us(3);
    rd(`TCQ_REG_FRAMES, 32'h2);
    line_in[0] <= 1'b0;
    wr(`TCQ_REG_STAT_SEL, {30'h0, `TCQ_SEL_AWAIT});
    camera_idle_in <= 1'b1;
    rd(`TCQ_REG_STATUS, 32'h1, 32'h1);
    wr(`TCQ_REG_SW_TRIG, 32'h1);
    repeat (4) @(posedge clk_in);
    rd(`TCQ_REG_FRAMES, 32'h3);
    camera_idle_in <= 1'b0;
    rd(`TCQ_REG_STATUS, 32'h0, 32'h1);
    wr(`TCQ_REG_SW_TRIG, 32'h1);
    repeat (4) @(posedge clk_in);
    rd(`TCQ_REG_FRAMES, 32'h3);
    wr(`TCQ_REG_CTRL, 32'h1);
    evq.push_back(`TCQ_EVT_EXPOSURE);
    pulse_exp;
    drain;
    wr(`TCQ_REG_CTRL, 32'h2);
    pulse_exp;
    us(1);
    // Stalled host: the queue fills, two events drop, overrun follows.
    stall <= 1'b1;
    wr(`TCQ_REG_CTRL, 32'h3);
    repeat (8) evq.push_back(`TCQ_EVT_EXPOSURE);
    evq.push_back(`TCQ_EVT_OVERRUN);
    repeat (10) pulse_exp;
    rd(`TCQ_REG_QLEVEL, 32'h8);
    rd(`TCQ_REG_STATUS, 32'h20000, 32'h20000);
    stall <= 1'b0;
    slow <= 1'b1;
    drain;
    rd(`TCQ_REG_QLEVEL, 32'h0);
    // Free-run takes no software trigger, so the ready flag is low.
    wr(`TCQ_REG_CTRL, 32'h4);
    camera_idle_in <= 1'b1;
    rd(`TCQ_REG_STATUS, 32'h0, 32'h1);
    us(1);
    print_verdict;
  end
endmodule // trigger_conditioning_event_queue_tb
